// ### opr_core.sv
`timescale 1ns/1ps
module opr_core
	import opr_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic chip_init_low,
	input wire logic dc_strap,
	input wire logic bit_valid,
	input wire logic bit_data,
	input wire logic frame_end,
	output logic [6:0] slave_addr,
	output logic display_on,
	output logic [5:0] mux_ratio,
	output logic seg_remap,
	output logic com_reverse,
	output logic [5:0] start_line,
	output logic [6:0] column_addr,
	output logic [7:0] contrast,
	output logic all_pixels_on,
	output logic [7:0] shift_data,
	output logic [2:0] shift_count
);

	// Only one command takes an argument byte, so two states suffice
	typedef enum logic [1:0]
	{
		OPR_IDLE = 2'b00,
		OPR_ARG_CONTRAST = 2'b01
	} opr_arg_e;

	typedef struct packed
	{
		logic [6:0] addr;
		logic disp;
		logic [5:0] mux;
		logic seg;
		logic com;
		logic [5:0] start;
		logic [6:0] col;
		logic [7:0] con;
		logic allon;
		// Serial shift state
		logic [7:0] sh;
		logic [2:0] cnt;
		opr_arg_e arg;
	} opr_state_s;

	// Synchronised pin levels
	logic init_n_s;
	logic strap_s;
	opr_state_s st_ff;
	opr_state_s nxt_st;
	logic [7:0] byte_in;

	// Pin inputs cross in through two flops each
	opr_sync u_sync_init
	(
		.mclk(mclk),
		.rst(rst),
		.din(chip_init_low),
		.dout(init_n_s)
	);

	opr_sync u_sync_strap
	(
		.mclk(mclk),
		.rst(rst),
		.din(dc_strap),
		.dout(strap_s)
	);

	// Byte as it will stand once the current bit is shifted in
	assign byte_in = {st_ff.sh[6:0], bit_data};

	// Priority: init pin, then frame_end, then a bit
	// The strap is not gated by init, since a tie is static
	always_comb
	begin
		// Hold everything unless something below changes it
		nxt_st = st_ff;
		// Strap followed continuously so a late tie settles without a reset
		nxt_st.addr = strap_s ? OPR_ADDR_ALT : OPR_ADDR_BASE;
		if (!init_n_s)
		begin
			nxt_st.disp = 1'b0;
			nxt_st.mux = OPR_MUX_RST;
			nxt_st.seg = 1'b0;
			nxt_st.com = 1'b0;
			nxt_st.start = OPR_START_RST;
			nxt_st.col = OPR_COL_RST;
			nxt_st.con = OPR_CONTRAST_RST;
			nxt_st.allon = 1'b0;
			// Partial serial bits are lost on init
			nxt_st.sh = 8'h00;
			nxt_st.cnt = 3'h0;
			nxt_st.arg = OPR_IDLE;
		end
		else if (frame_end)
		begin
			// Abandoned partial bytes never leak into the next frame
			nxt_st.sh = 8'h00;
			nxt_st.cnt = 3'h0;
		end
		else if (bit_valid)
		begin
			nxt_st.sh = byte_in;
			nxt_st.cnt = st_ff.cnt + 3'h1;
			// Command acts on the edge that takes the eighth bit
			if (st_ff.cnt == 3'h7)
			begin
				unique case (st_ff.arg)
					OPR_ARG_CONTRAST:
					begin
						nxt_st.con = byte_in;
						nxt_st.arg = OPR_IDLE;
					end
					OPR_IDLE:
					begin
						// Bytes that match nothing are dropped, not an error
						if (byte_in == OPR_CMD_DISP_OFF)
							nxt_st.disp = 1'b0;
						else if (byte_in == OPR_CMD_DISP_ON)
							nxt_st.disp = 1'b1;
						else if (byte_in == OPR_CMD_CONTRAST)
							nxt_st.arg = OPR_ARG_CONTRAST;
						else if (byte_in == OPR_CMD_SEG_NORM)
							nxt_st.seg = 1'b0;
						else if (byte_in == OPR_CMD_SEG_REMAP)
							nxt_st.seg = 1'b1;
						else if (byte_in == OPR_CMD_FOLLOW_RAM)
							nxt_st.allon = 1'b0;
						else if (byte_in == OPR_CMD_ALL_ON)
							nxt_st.allon = 1'b1;
						else if (byte_in == OPR_CMD_COM_NORM)
							nxt_st.com = 1'b0;
						else if (byte_in == OPR_CMD_COM_REV)
							nxt_st.com = 1'b1;
						else if (byte_in[7:4] == OPR_CMD_COL_LO[7:4])
							nxt_st.col = {st_ff.col[6:4], byte_in[3:0]};
						else if (byte_in[7:4] == OPR_CMD_COL_HI[7:4])
							nxt_st.col = {byte_in[2:0], st_ff.col[3:0]};
						else if (byte_in[7:6] == OPR_CMD_START[7:6])
							nxt_st.start = byte_in[5:0];
					end
					default:
						nxt_st.arg = OPR_IDLE;
				endcase
			end
		end
	end

	// Async reset loads the same values as the init pin, so outputs are
	// defined before the synchronisers have filled
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			st_ff.addr <= OPR_ADDR_BASE;
			st_ff.disp <= 1'b0;
			st_ff.mux <= OPR_MUX_RST;
			st_ff.seg <= 1'b0;
			st_ff.com <= 1'b0;
			st_ff.start <= OPR_START_RST;
			st_ff.col <= OPR_COL_RST;
			st_ff.con <= OPR_CONTRAST_RST;
			st_ff.allon <= 1'b0;
			st_ff.sh <= 8'h00;
			st_ff.cnt <= 3'h0;
			st_ff.arg <= OPR_IDLE;
		end
		else
			st_ff <= nxt_st;
	end

	// Outputs are taken straight from the state register
	assign slave_addr = st_ff.addr;
	assign display_on = st_ff.disp;
	assign mux_ratio = st_ff.mux;
	assign seg_remap = st_ff.seg;
	assign com_reverse = st_ff.com;
	assign start_line = st_ff.start;
	assign column_addr = st_ff.col;
	assign contrast = st_ff.con;
	assign all_pixels_on = st_ff.allon;
	assign shift_data = st_ff.sh;
	assign shift_count = st_ff.cnt;
endmodule

// ### opr_pkg.sv
package opr_pkg;
	localparam logic [6:0] OPR_ADDR_BASE = 7'h3c;
	localparam logic [6:0] OPR_ADDR_ALT = 7'h3d;
	localparam logic [7:0] OPR_CONTRAST_RST = 8'h7f;
	localparam logic [5:0] OPR_MUX_RST = 6'h3f;
	localparam logic [5:0] OPR_START_RST = 6'h00;
	localparam logic [6:0] OPR_COL_RST = 7'h00;
	localparam logic [7:0] OPR_CMD_DISP_OFF = 8'hae;
	localparam logic [7:0] OPR_CMD_DISP_ON = 8'haf;
	localparam logic [7:0] OPR_CMD_CONTRAST = 8'h81;
	localparam logic [7:0] OPR_CMD_SEG_NORM = 8'ha0;
	localparam logic [7:0] OPR_CMD_SEG_REMAP = 8'ha1;
	localparam logic [7:0] OPR_CMD_FOLLOW_RAM = 8'ha4;
	localparam logic [7:0] OPR_CMD_ALL_ON = 8'ha5;
	localparam logic [7:0] OPR_CMD_COM_NORM = 8'hc0;
	localparam logic [7:0] OPR_CMD_COM_REV = 8'hc8;
	localparam logic [7:0] OPR_CMD_COL_LO = 8'h00;
	localparam logic [7:0] OPR_CMD_COL_HI = 8'h10;
	localparam logic [7:0] OPR_CMD_START = 8'h40;
endpackage

// ### opr_sync.sv
`timescale 1ns/1ps
module opr_sync
	import opr_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic din,
	output logic dout
);
	logic meta_ff;
	logic hold_ff;
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			meta_ff <= 1'b0;
			hold_ff <= 1'b0;
		end
		else
		begin
			meta_ff <= din;
			hold_ff <= meta_ff;
		end
	end
	assign dout = hold_ff;
endmodule

// ### opr_core_chk.sv
`timescale 1ns/1ps
module opr_core_chk(
	input wire logic mclk,
	input wire logic rst,
	input wire logic chip_init_low,
	input wire logic dc_strap,
	input wire logic frame_end,
	input wire logic [6:0] slave_addr,
	input wire logic display_on,
	input wire logic seg_remap,
	input wire logic com_reverse,
	input wire logic [7:0] contrast,
	input wire logic all_pixels_on,
	input wire logic [2:0] shift_count
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	a_strap_hi: assert property (dc_strap [*5] |-> slave_addr == 7'h3d)
		else $error("addr");
	a_strap_lo: assert property (!dc_strap [*5] |-> slave_addr == 7'h3c)
		else $error("addr");
	a_init_disp: assert property ($fell(chip_init_low) |-> ##3 !display_on)
		else $error("init");
	a_init_con: assert property (!chip_init_low [*5] |-> contrast == 8'h7f)
		else $error("init");
	a_init_map: assert property (!chip_init_low [*5] |-> !seg_remap && !com_reverse)
		else $error("init");
	a_init_mode: assert property (!chip_init_low [*5] |-> !all_pixels_on)
		else $error("init");
	a_init_shift: assert property (!chip_init_low [*5] |-> shift_count == 3'h0)
		else $error("init");
	a_frame_clr: assert property (frame_end |=> shift_count == 3'h0)
		else $error("count");
endmodule
bind opr_core opr_core_chk u_chk (.*);

// ### opr_host.sv
`timescale 1ns/1ps
module opr_host(
	input wire logic mclk,
	output logic bit_valid = 1'h0,
	output logic bit_data = 1'h0
);
	logic logic_sup = 1'h0;
	logic drive_sup = 1'h0; // Off means released, never pulled low
	// Scaled stand-in for the long supply settle times
	localparam int SETTLE_CYC = 20;
	task automatic power_up();
		logic_sup = 1'h1;
		send(8'hae, 8);
		drive_sup = 1'h1;
		repeat (SETTLE_CYC) @(negedge mclk);
		send(8'haf, 8);
	endtask
	task automatic power_down();
		send(8'hae, 8);
		drive_sup = 1'h0;
		repeat (SETTLE_CYC) @(negedge mclk);
		if (!drive_sup)
			logic_sup = 1'h0;
	endtask
	task automatic send(logic [7:0] b, int n);
		for (int i = 7; i > 7 - n; i--)
		begin
			@(negedge mclk);
			bit_valid = 1'h1;
			bit_data = b[i];
		end
		@(negedge mclk);
		bit_valid = 1'h0;
		bit_data = ~bit_data; // Undriven line must not hold the last bit
	endtask
endmodule

// ### oled_power_reset_sequencing_tb_top.sv
`timescale 1ns/1ps
module oled_power_reset_sequencing_tb_top;
	logic mclk = 1'h0, rst = 1'h1, chip_init_low = 1'h1, dc_strap = 1'h0, frame_end = 1'h0;
	logic bit_valid, bit_data, display_on, seg_remap, com_reverse, all_pixels_on;
	logic [6:0] slave_addr, column_addr;
	logic [5:0] mux_ratio, start_line;
	logic [7:0] contrast, shift_data;
	logic [2:0] shift_count;
	logic [11:0] rows [9] = '{12'haf8, 12'hae0, 12'hc82, 12'hc00, 12'ha14, 12'ha00, 12'ha51,
		12'ha40, 12'hc82};
	int error_cnt = 0, n_checks = 0;
	wire logic [33:0] st = {display_on, seg_remap, com_reverse, all_pixels_on, mux_ratio,
		start_line, column_addr, contrast, shift_count};
	opr_host HOST (.*);
	opr_core DUT (.*);
	initial forever #5 mclk = ~mclk;
	task automatic chk(string nm, logic [33:0] e, logic [33:0] g);
		n_checks++;
		if (g !== e)
		begin
			error_cnt++;
			$display("wrong value %s %h %h", nm, e, g);
		end
	endtask
	task automatic final_report();
		if (error_cnt == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial
	begin
		// Whole sequence is a few hundred cycles; generous margin
		#10us;
		error_cnt++;
		final_report();
	end
	initial
	begin
		repeat (2) @(negedge mclk);
		rst = 1'h0;
		repeat (3) @(negedge mclk);
		HOST.power_up();
		chk("power_up", 34'h1, display_on);
		foreach (rows[i])
		begin
			HOST.send(rows[i][11:4], 8);
			chk("flags", rows[i][3:0], st[33:30]);
		end
		HOST.send(8'h81, 8);
		HOST.send(8'h32, 8);
		HOST.send(8'h55, 8);
		HOST.send(8'h05, 8);
		HOST.send(8'hff, 3);
		chk("shift", {8'h2f, 3'h3}, {shift_data, shift_count});
		frame_end = 1'h1;
		@(negedge mclk);
		frame_end = 1'h0;
		chk("state", {4'h2, 6'h3f, 6'h15, 7'h05, 8'h32, 3'h0}, st);
		HOST.send(8'haf, 8);
		chk("on", 34'h1, display_on);
		HOST.send(8'hff, 5);
		chip_init_low = 1'h0;
		repeat (4) @(negedge mclk);
		HOST.send(8'haf, 8);
		chk("init", {4'h0, 6'h3f, 13'h0, 8'h7f, 3'h0}, st);
		chk("init_shift", 34'h0, shift_data);
		chip_init_low = 1'h1;
		dc_strap = 1'h1;
		repeat (5) @(negedge mclk);
		chk("addr", 34'h3d, slave_addr);
		HOST.power_down();
		chk("power_down", 34'h0, {HOST.logic_sup, HOST.drive_sup, display_on});
		final_report();
	end
endmodule
